// [verilog/pdi_pkg.sv]
// Constants and types for the potentiometer two-wire slave.
package pdi_pkg;
	localparam int SYNC_N = 3;
	localparam logic [4:0] ADDR_HI = 5'h0A;
	localparam logic [1:0] LSB_LOW = 2'h0;
	localparam logic [1:0] LSB_OPEN = 2'h1;
	localparam logic [1:0] LSB_HIGH = 2'h3;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET = 8'h06;
	localparam logic [7:0] REG_TAP = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h80;
	localparam logic [7:0] ONES = 8'hFF;
	localparam logic [7:0] TAP_RST = 8'h80;
	localparam logic [7:0] TAP_ZERO = 8'h00;
	localparam logic [7:0] TAP_MID = 8'h80;
	localparam logic [7:0] TAP_FULL = 8'hFF;
	localparam logic [3:0] BIT_DONE = 4'h8;
	localparam logic [3:0] PIN_RST = 4'h3;
	typedef struct packed {
		logic pump;
		logic high_open;
		logic low_open;
		logic tap_open;
		logic [1:0] sel;
	} pdi_cfg_s;
	localparam pdi_cfg_s CFG_RST = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0};
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_ACK = 3'h2,
		ST_TX = 3'h3,
		ST_RACK = 3'h4,
		ST_SKIP = 3'h5
	} pdi_state_e;
endpackage : pdi_pkg

// [verilog/pdi_slave.sv]
// Two-wire slave with tap and config readback for the potentiometer.
`timescale 1ns/1ps
`default_nettype none
module pdi_slave (
	input wire logic clk_sys, // System clock, 50 MHz.
	input wire logic sys_rst, // Synchronous reset, high.
	input wire logic scl_in, // Bus clock pin level.
	input wire logic sda_in, // Bus data pin level.
	output logic sda_out, // Data drive value, always low.
	output logic sda_oe, // High while pulling SDA low.
	input wire logic strap_pu_lvl, // Strap level with pullup on.
	input wire logic strap_pd_lvl, // Strap level with pulldown on.
	output logic [7:0] wiper_pos, // Effective wiper code.
	output logic pump_on_flag, // Charge pump enabled.
	output logic high_term_open, // High terminal open.
	output logic low_term_open, // Low terminal open.
	output logic tap_term_open, // Wiper terminal open.
	output logic [1:0] tap_override_sel // Wiper source select.
);
	logic [3:0] pins, sy1, sy2, sy3, filt, next_filt;
	logic scl_q, sda_q, scl, sda;
	logic scl_rise, scl_fall, start_det, stop_det, stop_ok;
	logic [2:0] cap, next_cap;
	logic [1:0] lsb, next_lsb;
	logic [6:0] own;

	assign pins = {strap_pd_lvl, strap_pu_lvl, sda_in, scl_in};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flt
			always_comb begin
				next_filt[gi] = (sy2[gi] == sy3[gi]) ? sy3[gi] : filt[gi];
			end
		end
	endgenerate
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sy1 <= pdi_pkg::PIN_RST;
			sy2 <= pdi_pkg::PIN_RST;
			sy3 <= pdi_pkg::PIN_RST;
			filt <= pdi_pkg::PIN_RST;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cap <= 3'h0;
			lsb <= pdi_pkg::LSB_OPEN;
		end else begin
			sy1 <= pins;
			sy2 <= sy1;
			sy3 <= sy2;
			filt <= next_filt;
			scl_q <= filt[0];
			sda_q <= filt[1];
			cap <= next_cap;
			lsb <= next_lsb;
		end
	end
	assign scl = filt[0];
	assign sda = filt[1];
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	assign start_det = scl & scl_q & sda_q & ~sda;
	assign stop_det = scl & scl_q & ~sda_q & sda;
	assign own = {pdi_pkg::ADDR_HI, lsb};

	// Strap is taken once the filter pipe has filled after reset.
	// The strap level needs four clocks to reach the filter output.
	always_comb begin
		next_cap = (cap == 3'h7) ? cap : cap + 3'h1;
		next_lsb = lsb;
		if (cap == 3'h4) begin
			if (filt[3])
				next_lsb = pdi_pkg::LSB_HIGH;
			else if (!filt[2])
				next_lsb = pdi_pkg::LSB_LOW;
			else
				next_lsb = pdi_pkg::LSB_OPEN;
		end
	end

	pdi_pkg::pdi_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [1:0] byte_n, next_byte_n;
	logic [7:0] rx_sh, next_rx, tx_sh, next_tx, load;
	logic [7:0] sel, next_sel, cmd_b, next_cmd, data_b, next_data;
	logic [7:0] tap, next_tap, next_wip;
	logic rd, next_rd, gc, next_gc, full, next_full;
	logic st_hi, next_st_hi, nack, next_nack, next_oe;
	pdi_pkg::pdi_cfg_s cfg, next_cfg;

	assign stop_ok = stop_det & ~st_hi;

	always_comb begin
		case (sel)
			pdi_pkg::REG_TAP: load = tap;
			pdi_pkg::REG_CFG: load = {cfg.pump, 2'b00, cfg.high_open,
				cfg.low_open, cfg.tap_open, cfg.sel};
			default: load = pdi_pkg::ONES;
		endcase
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_byte_n = byte_n;
		next_rx = rx_sh;
		next_tx = tx_sh;
		next_sel = sel;
		next_cmd = cmd_b;
		next_data = data_b;
		next_tap = tap;
		next_rd = rd;
		next_gc = gc;
		next_full = full;
		next_st_hi = st_hi;
		next_nack = nack;
		next_cfg = cfg;
		if (scl_fall)
			next_st_hi = 1'b0;
		if (scl_rise && cnt != pdi_pkg::BIT_DONE) begin
			next_cnt = cnt + 4'h1;
			next_rx = {rx_sh[6:0], sda};
		end
		if (scl_rise && state == pdi_pkg::ST_RACK)
			next_nack = sda;
		if (scl_fall) begin
			case (state)
				pdi_pkg::ST_RX: begin
					if (cnt == pdi_pkg::BIT_DONE) begin
						next_state = pdi_pkg::ST_ACK;
						if (byte_n != 2'h3)
							next_byte_n = byte_n + 2'h1;
						case (byte_n)
							2'h0: begin
								if (rx_sh[7:1] == own) begin
									next_rd = rx_sh[0];
									next_gc = 1'b0;
								end else if (rx_sh == pdi_pkg::GC_ADDR) begin
									next_gc = 1'b1;
									next_rd = 1'b0;
								end else begin
									next_state = pdi_pkg::ST_SKIP;
								end
							end
							2'h1: begin
								next_cmd = rx_sh;
								if (gc)
									next_full = (rx_sh == pdi_pkg::GC_RESET);
								else
									next_sel = rx_sh;
							end
							2'h2: begin
								next_data = rx_sh;
								if (!gc)
									next_full = 1'b1;
							end
							default: ;
						endcase
					end
				end
				pdi_pkg::ST_ACK: begin
					next_cnt = 4'h0;
					if (rd) begin
						next_state = pdi_pkg::ST_TX;
						next_tx = load;
					end else begin
						next_state = pdi_pkg::ST_RX;
					end
				end
				pdi_pkg::ST_TX: begin
					if (cnt == pdi_pkg::BIT_DONE)
						next_state = pdi_pkg::ST_RACK;
					else
						next_tx = {tx_sh[6:0], 1'b1};
				end
				pdi_pkg::ST_RACK: begin
					if (nack) begin
						next_state = pdi_pkg::ST_SKIP;
					end else begin
						next_state = pdi_pkg::ST_TX;
						next_tx = pdi_pkg::ONES;
						next_cnt = 4'h0;
					end
				end
				default: ;
			endcase
		end
		if (start_det) begin
			next_state = pdi_pkg::ST_RX;
			next_cnt = 4'h0;
			next_byte_n = 2'h0;
			next_full = 1'b0;
			next_st_hi = 1'b1;
			next_rd = 1'b0;
			next_gc = 1'b0;
		end
		if (stop_ok) begin
			next_state = pdi_pkg::ST_IDLE;
			next_full = 1'b0;
			if (full && gc) begin
				next_tap = pdi_pkg::TAP_RST;
				next_cfg = pdi_pkg::CFG_RST;
			end else if (full && cmd_b == pdi_pkg::REG_TAP) begin
				next_tap = data_b;
			end
		end
		next_oe = (next_state == pdi_pkg::ST_ACK) ||
			(next_state == pdi_pkg::ST_TX && !next_tx[7]);
		case (next_cfg.sel)
			2'h1: next_wip = pdi_pkg::TAP_ZERO;
			2'h2: next_wip = pdi_pkg::TAP_MID;
			2'h3: next_wip = pdi_pkg::TAP_FULL;
			default: next_wip = next_tap;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= pdi_pkg::ST_IDLE;
			cnt <= 4'h0;
			byte_n <= 2'h0;
			rx_sh <= 8'h00;
			tx_sh <= pdi_pkg::ONES;
			sel <= pdi_pkg::REG_TAP;
			cmd_b <= 8'h00;
			data_b <= 8'h00;
			tap <= pdi_pkg::TAP_RST;
			rd <= 1'b0;
			gc <= 1'b0;
			full <= 1'b0;
			st_hi <= 1'b0;
			nack <= 1'b1;
			cfg <= pdi_pkg::CFG_RST;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			wiper_pos <= pdi_pkg::TAP_RST;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			byte_n <= next_byte_n;
			rx_sh <= next_rx;
			tx_sh <= next_tx;
			sel <= next_sel;
			cmd_b <= next_cmd;
			data_b <= next_data;
			tap <= next_tap;
			rd <= next_rd;
			gc <= next_gc;
			full <= next_full;
			st_hi <= next_st_hi;
			nack <= next_nack;
			cfg <= next_cfg;
			sda_oe <= next_oe;
			sda_out <= 1'b0;
			wiper_pos <= next_wip;
		end
	end
	assign pump_on_flag = cfg.pump;
	assign high_term_open = cfg.high_open;
	assign low_term_open = cfg.low_open;
	assign tap_term_open = cfg.tap_open;
	assign tap_override_sel = cfg.sel;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_byte_in;
		state == pdi_pkg::ST_RX && cnt == pdi_pkg::BIT_DONE && scl_fall && byte_n == 2'h0;
	endsequence
	sequence s_bad_addr;
		s_byte_in ##0 (rx_sh[7:1] != own && rx_sh != pdi_pkg::GC_ADDR);
	endsequence

	a_start_rx: assert property (start_det |=> state == pdi_pkg::ST_RX && byte_n == 2'h0)
		else $error("start did not open a byte");
	a_stop_idle: assert property (stop_ok |=> state == pdi_pkg::ST_IDLE)
		else $error("stop not honoured");
	a_sr_drop: assert property (start_det |=> !full)
		else $error("pending write survived a start");
	a_tap_quiet: assert property ($changed(tap) |-> $past(stop_ok && full))
		else $error("tap changed outside a completed write");
	a_ack_hold: assert property (state == pdi_pkg::ST_ACK |-> sda_oe)
		else $error("acknowledge not driven");
	a_tx_bit: assert property (state == pdi_pkg::ST_TX |-> sda_oe == !tx_sh[7])
		else $error("read bit mismatch");
	a_extra_ones: assert property (state == pdi_pkg::ST_RACK && scl_fall && !nack && !start_det
		&& !stop_ok |=> tx_sh == pdi_pkg::ONES)
		else $error("extra byte not all ones");
	a_nomatch: assert property (s_bad_addr ##1 !sda_oe |-> state == pdi_pkg::ST_SKIP)
		else $error("foreign address not ignored");
	a_skip_quiet: assert property (state == pdi_pkg::ST_SKIP |-> !sda_oe)
		else $error("SDA driven while ignoring");
	a_gc_reset: assert property (stop_ok && full && gc |=> tap == pdi_pkg::TAP_RST
		&& pump_on_flag)
		else $error("software reset not applied");
	a_drive_low: assert property (sda_out == 1'b0)
		else $error("SDA driven high");
	a_rack_free: assert property (state == pdi_pkg::ST_RACK |-> !sda_oe)
		else $error("SDA driven during master acknowledge");
	a_oe_only: assert property (sda_oe |-> state == pdi_pkg::ST_ACK || state == pdi_pkg::ST_TX)
		else $error("SDA driven outside acknowledge or read");
	a_tx_load: assert property (state == pdi_pkg::ST_ACK && rd && scl_fall |=> tx_sh == $past(load))
		else $error("read byte not restarted from first bit");
endmodule : pdi_slave
`default_nettype wire

// [dv/pdi_master_model.sv]
// Bus master model that clocks the two-wire link of the slave.
`timescale 1ns/1ps
`default_nettype none
module pdi_master_model (
	input wire logic clk_sys, // System clock.
	input wire logic sda_wire, // Resolved data line.
	output logic scl, // Bus clock, idle high.
	output logic sda_low // High while pulling data low.
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : q
	// Data moves only in mid low phase; each phase lasts eight system clocks.
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		q(4);
		scl <= 1'b1;
		q(4);
		r = sda_wire;
		q(4);
		scl <= 1'b0;
		q(4);
	endtask : bit_io
	// The high pulse of a start always ends with clock low, never with a stop.
	task automatic start();
		sda_low <= 1'b0;
		q(4);
		scl <= 1'b1;
		q(4);
		sda_low <= 1'b1;
		q(4);
		scl <= 1'b0;
		q(4);
	endtask : start
	task automatic stop();
		sda_low <= 1'b1;
		q(4);
		scl <= 1'b1;
		q(4);
		sda_low <= 1'b0;
		q(16);
	endtask : stop
	task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
		output logic seen);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ak, seen);
	endtask : xfer
endmodule : pdi_master_model
`default_nettype wire

// [dv/pdi_slave_test.sv]
// Self-checking bench for the potentiometer two-wire slave.
`timescale 1ns/1ps
`default_nettype none
module pdi_slave_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic pu = 1'b0;
	logic pd = 1'b0;
	logic scl, sda_low, sda_oe, sda_wire, pump, hi_o, lo_o, tap_o, ack, drv;
	logic [1:0] sel;
	logic [7:0] wiper, rx;
	logic [6:0] dev = 7'h28;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 clk_sys = ~clk_sys;
	assign sda_wire = !(sda_oe | sda_low);
	pdi_master_model i_mst (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl),
		.sda_low(sda_low));
	pdi_slave i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(drv), .sda_oe(sda_oe), .strap_pu_lvl(pu), .strap_pd_lvl(pd), .wiper_pos(wiper),
		.pump_on_flag(pump), .high_term_open(hi_o), .low_term_open(lo_o),
		.tap_term_open(tap_o), .tap_override_sel(sel));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic do_reset(input logic u, input logic d);
		@(posedge clk_sys);
		pu <= u;
		pd <= d;
		sys_rst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (16) @(posedge clk_sys);
	endtask : do_reset
	task automatic put(input logic [7:0] b, input logic nak);
		i_mst.xfer(b, 1'b1, rx, ack);
		check("ack", {7'h0, ack}, {7'h0, nak});
	endtask : put
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
		input logic nak);
		i_mst.start();
		put({a, 1'b0}, nak);
		put(c, nak);
		put(d, nak);
		i_mst.stop();
	endtask : wr
	task automatic rd(input logic [7:0] s, input logic [7:0] exp);
		i_mst.start();
		put({dev, 1'b0}, 1'b0);
		put(s, 1'b0);
		i_mst.start();
		put({dev, 1'b1}, 1'b0);
		i_mst.xfer(8'hFF, 1'b0, rx, ack);
		check("read", rx, exp);
		i_mst.xfer(8'hFF, 1'b1, rx, ack);
		check("extra", rx, 8'hFF);
		i_mst.stop();
	endtask : rd
	task automatic gc(input logic [7:0] b);
		i_mst.start();
		put(pdi_pkg::GC_ADDR, 1'b0);
		put(b, 1'b0);
		i_mst.stop();
	endtask : gc
	task automatic t_reset();
		check("wiper", wiper, pdi_pkg::TAP_RST);
		check("cfg", {2'h0, pump, hi_o, lo_o, tap_o, sel}, 8'h20);
		check("sda_out", {7'h0, drv}, 8'h00);
		rd(pdi_pkg::REG_CFG, 8'h80);
		rd(8'h12, 8'hFF);
		$display("reset test done");
	endtask : t_reset
	task automatic t_write();
		wr(dev, pdi_pkg::REG_TAP, 8'h5A, 1'b0);
		check("wiper", wiper, 8'h5A);
		wr(dev, pdi_pkg::REG_CFG, 8'h11, 1'b0);
		check("wiper", wiper, 8'h5A);
		rd(pdi_pkg::REG_TAP, 8'h5A);
		$display("write test done");
	endtask : t_write
	task automatic t_abort();
		i_mst.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h00, 1'b0);
		put(8'h33, 1'b0);
		i_mst.start();
		put(8'h54, 1'b1);
		i_mst.stop();
		check("wiper", wiper, 8'h5A);
		i_mst.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h00, 1'b0);
		for (int i = 0; i < 4; i++) begin
			i_mst.bit_io(1'b0, ack);
		end
		i_mst.stop();
		check("wiper", wiper, 8'h5A);
		$display("abort test done");
	endtask : t_abort
	task automatic t_rdstop();
		i_mst.start();
		put({dev, 1'b0}, 1'b0);
		put(8'h00, 1'b0);
		i_mst.start();
		put({dev, 1'b1}, 1'b0);
		for (int i = 0; i < 3; i++) begin
			i_mst.bit_io(1'b1, ack);
		end
		i_mst.stop();
		rd(pdi_pkg::REG_TAP, 8'h5A);
		$display("read stop test done");
	endtask : t_rdstop
	task automatic t_gc();
		gc(8'h05);
		check("wiper", wiper, 8'h5A);
		gc(pdi_pkg::GC_RESET);
		check("wiper", wiper, pdi_pkg::TAP_RST);
		$display("general call test done");
	endtask : t_gc
	task automatic t_strap();
		logic [6:0] adr [3] = '{7'h28, 7'h29, 7'h2B};
		for (int k = 0; k < 3; k++) begin
			do_reset(k > 0, k > 1);
			dev = adr[k];
			wr(adr[(k + 1) % 3], 8'h00, 8'h44, 1'b1);
			wr(dev, 8'h00, 8'h44, 1'b0);
			check("wiper", wiper, 8'h44);
			wr(dev, 8'h00, {dev, 1'b1}, 1'b0);
			check("wiper", wiper, {dev, 1'b1});
		end
		$display("strap test done");
	endtask : t_strap
	initial begin
		do_reset(1'b0, 1'b0);
		t_reset();
		t_write();
		t_abort();
		t_rdstop();
		t_gc();
		t_strap();
		conclude();
	end
endmodule : pdi_slave_test
`default_nettype wire
